// File: verilog/wdr_pkg.sv
// Package: constants for the watchdog with reset routing
package wdr_pkg;
  // Configuration port addresses and keys
  localparam logic [15:0] WDR_INDEX_PORT = 16'h004E;
  localparam logic [15:0] WDR_DATA_PORT = 16'h004F;
  localparam logic [7:0] WDR_UNLOCK_KEY = 8'h55;
  localparam logic [7:0] WDR_LOCK_KEY = 8'hAA;
  localparam logic [7:0] WDR_IDX_LDN = 8'h07;
  localparam logic [7:0] WDR_LDN_WDT = 8'h0A;
  localparam logic [7:0] WDR_IDX_BASE_HI = 8'h60;
  localparam logic [7:0] WDR_IDX_BASE_LO = 8'h61;
  // Runtime register offsets
  localparam logic [7:0] WDR_OFS_RST_SRC = 8'h1D;
  localparam logic [7:0] WDR_OFS_PIN_CFG = 8'h47;
  localparam logic [7:0] WDR_OFS_UNIT = 8'h65;
  localparam logic [7:0] WDR_OFS_COUNT = 8'h66;
  localparam logic [7:0] WDR_OFS_CTRL = 8'h67;
  // Field positions
  localparam int WDR_RST_WDT_DIS = 0;
  localparam int WDR_RST_THERM = 1;
  localparam int WDR_RST_WDT2 = 2;
  localparam int WDR_PIN_DIR = 0;
  localparam int WDR_PIN_POL = 1;
  localparam int WDR_PIN_FN_LO = 2;
  localparam int WDR_PIN_OD = 7;
  localparam int WDR_UNIT_SEC = 7;
  localparam int WDR_CTRL_TO = 0;
  // Writable masks (reserved bits read zero)
  localparam logic [7:0] WDR_RST_MASK = 8'h07;
  localparam logic [7:0] WDR_PIN_MASK = 8'h8F;
  localparam logic [7:0] WDR_UNIT_MASK = 8'h80;
  // Reset values
  localparam logic [7:0] WDR_RST_RESET = 8'h00;
  localparam logic [7:0] WDR_PIN_RESET = 8'h01;
  localparam logic [7:0] WDR_UNIT_RESET = 8'h00;
  localparam logic [7:0] WDR_COUNT_RESET = 8'h00;
  localparam logic [15:0] WDR_BASE_RESET = 16'h0A00;
  // Alternate function codes
  localparam logic [1:0] WDR_FN_GPIO = 2'h0;
  localparam logic [1:0] WDR_FN_LED = 2'h1;
  localparam logic [1:0] WDR_FN_EDGE = 2'h2;
  localparam logic [1:0] WDR_FN_WDT = 2'h3;
  // Time base
  localparam int WDR_CLK_MHZ = 250;
  localparam int WDR_SECOND_S = 1;
  localparam int WDR_SEC_PER_MIN = 60;
  localparam longint WDR_SEC_CYCLES = longint'(WDR_SECOND_S) * 64'd250000000;
endpackage : wdr_pkg

// File: verilog/wdr_watchdog.sv
// Watchdog timer with reset routing behind a configuration I/O port
`timescale 1ns/1ps
`default_nettype none
module wdr_watchdog
  import wdr_pkg::*;
#(
  parameter longint SEC_CYCLES = WDR_SEC_CYCLES,
  parameter int MIN_SECONDS = WDR_SEC_PER_MIN
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Host I/O cycle, same clock domain
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // System pins
  input wire logic thermal_trip,
  output logic power_good_output,
  input wire logic mp_pin_in,
  output logic mp_pin_out,
  output logic mp_pin_oe,
  // Alternate function sideband
  output logic led_on,
  output logic edge_event,
  output logic [7:0] gpio_level
);
  // ****************************************************************
  // Configuration port
  // ****************************************************************
  logic cfg_mode_r, cfg_mode_nxt;
  logic [7:0] index_r, index_nxt;
  logic [7:0] ldn_r, ldn_nxt;
  logic [15:0] base_r, base_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] rst_src_r, rst_src_nxt;
  logic [7:0] pin_cfg_r, pin_cfg_nxt;
  logic [7:0] unit_r, unit_nxt;
  logic [7:0] count_reg_r, count_reg_nxt;
  logic [7:0] count_r, count_nxt;
  logic timeout_r, timeout_nxt;
  logic [63:0] tick_r, tick_nxt;
  logic [7:0] min_r, min_nxt;
  logic [1:0] pin_sync_r, pin_sync_nxt;
  logic pin_last_r, pin_last_nxt;
  logic [1:0] therm_sync_r, therm_sync_nxt;

  // ****************************************************************
  // Runtime address decode
  // ****************************************************************

  // Runtime decode, reused by the read and write paths
  function automatic logic rt_hit(input logic [15:0] a, input logic [15:0] b,
                                  input logic [7:0] ofs);
    rt_hit = (a == (b + {8'h00, ofs}));
  endfunction : rt_hit

  logic cfg_data;
  logic rt_rst, rt_pin, rt_unit, rt_cnt, rt_ctrl;
  logic unit_tick, expired;
  logic pin_sync, therm_sync;
  assign pin_sync = pin_sync_r[1];
  assign therm_sync = therm_sync_r[1];
  assign cfg_data = cfg_mode_r && (io_addr == WDR_DATA_PORT);
  assign rt_rst = rt_hit(io_addr, base_r, WDR_OFS_RST_SRC);
  assign rt_pin = rt_hit(io_addr, base_r, WDR_OFS_PIN_CFG);
  assign rt_unit = rt_hit(io_addr, base_r, WDR_OFS_UNIT);
  assign rt_cnt = rt_hit(io_addr, base_r, WDR_OFS_COUNT);
  assign rt_ctrl = rt_hit(io_addr, base_r, WDR_OFS_CTRL);

  // ****************************************************************
  // Configuration port: unlock, index and logical device
  // ****************************************************************
  // Leaving program mode needs the lock key or a reset; nothing else closes it
  always_comb begin
    cfg_mode_nxt = cfg_mode_r;
    index_nxt = index_r;
    ldn_nxt = ldn_r;
    base_nxt = base_r;
    // Program mode entry and exit; the host is trusted to exit
    if (io_wr && io_addr == WDR_INDEX_PORT) begin
      if (io_wdata == WDR_UNLOCK_KEY) begin
        cfg_mode_nxt = 1'b1;
      end else if (cfg_mode_r && io_wdata == WDR_LOCK_KEY) begin
        cfg_mode_nxt = 1'b0;
      end else if (cfg_mode_r) begin
        index_nxt = io_wdata;
      end
    end
    if (io_wr && cfg_data) begin
      case (index_r)
        WDR_IDX_LDN: ldn_nxt = io_wdata;
        WDR_IDX_BASE_HI: if (ldn_r == WDR_LDN_WDT) base_nxt[15:8] = io_wdata;
        WDR_IDX_BASE_LO: if (ldn_r == WDR_LDN_WDT) base_nxt[7:0] = io_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_mode_r <= 1'b0;
      index_r <= 8'h00;
      ldn_r <= 8'h00;
      base_r <= WDR_BASE_RESET;
    end else if (clk_en) begin
      cfg_mode_r <= cfg_mode_nxt;
      index_r <= index_nxt;
      ldn_r <= ldn_nxt;
      base_r <= base_nxt;
    end
  end

  // ****************************************************************
  // Runtime registers and countdown
  // ****************************************************************
  // The tick counter is 64 bits so a full-rate second still fits
  // A count write restarts the tick phase as well as the count
  always_comb begin
    rst_src_nxt = rst_src_r;
    pin_cfg_nxt = pin_cfg_r;
    unit_nxt = unit_r;
    count_reg_nxt = count_reg_r;
    count_nxt = count_r;
    timeout_nxt = timeout_r;
    tick_nxt = tick_r;
    min_nxt = min_r;
    unit_tick = 1'b0;
    expired = 1'b0;
    // Time base: one second ticks, minutes count sixty of them
    if (count_r != 8'h00) begin
      if (tick_r >= 64'(SEC_CYCLES - 1)) begin
        tick_nxt = 64'h0;
        if (unit_r[WDR_UNIT_SEC] || min_r >= 8'(MIN_SECONDS - 1)) begin
          unit_tick = 1'b1;
          min_nxt = 8'h00;
        end else begin
          min_nxt = min_r + 8'h01;
        end
      end else begin
        tick_nxt = tick_r + 64'h1;
      end
    end else begin
      tick_nxt = 64'h0;
      min_nxt = 8'h00;
    end
    // Countdown halts at zero and flags timeout
    if (unit_tick) begin
      count_nxt = count_r - 8'h01;
      expired = (count_r == 8'h01);
    end
    if (io_wr) begin
      if (rt_rst) rst_src_nxt = io_wdata & WDR_RST_MASK;
      if (rt_pin) pin_cfg_nxt = io_wdata & WDR_PIN_MASK;
      if (rt_unit) unit_nxt = io_wdata & WDR_UNIT_MASK;
      if (rt_cnt) begin
        count_reg_nxt = io_wdata;
        count_nxt = io_wdata;
        tick_nxt = 64'h0;
        min_nxt = 8'h00;
        expired = 1'b0;
      end
      if (rt_ctrl) timeout_nxt = io_wdata[WDR_CTRL_TO];
    end
    // Expiry in the same cycle as a host control write of zero still sets; a count write cancels it
    if (expired) timeout_nxt = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_src_r <= WDR_RST_RESET;
      pin_cfg_r <= WDR_PIN_RESET;
      unit_r <= WDR_UNIT_RESET;
      count_reg_r <= WDR_COUNT_RESET;
      count_r <= WDR_COUNT_RESET;
      timeout_r <= 1'b0;
      tick_r <= 64'h0;
      min_r <= 8'h00;
    end else if (clk_en) begin
      // Frozen with the count so a paused clock loses no time
      rst_src_r <= rst_src_nxt;
      pin_cfg_r <= pin_cfg_nxt;
      unit_r <= unit_nxt;
      count_reg_r <= count_reg_nxt;
      count_r <= count_nxt;
      timeout_r <= timeout_nxt;
      tick_r <= tick_nxt;
      min_r <= min_nxt;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Registered so the host sees a stable byte until its next read
  always_comb begin
    rdata_nxt = rdata_r;
    if (io_rd) begin
      rdata_nxt = 8'h00;
      if (cfg_data) begin
        case (index_r)
          WDR_IDX_LDN: rdata_nxt = ldn_r;
          WDR_IDX_BASE_HI: rdata_nxt = base_r[15:8];
          WDR_IDX_BASE_LO: rdata_nxt = base_r[7:0];
          default: rdata_nxt = 8'h00;
        endcase
      end else if (io_addr == WDR_INDEX_PORT && cfg_mode_r) begin
        rdata_nxt = index_r;
      end else if (rt_rst) begin
        rdata_nxt = rst_src_r;
      end else if (rt_pin) begin
        rdata_nxt = pin_cfg_r;
      end else if (rt_unit) begin
        rdata_nxt = unit_r;
      end else if (rt_cnt) begin
        rdata_nxt = count_r;
      end else if (rt_ctrl) begin
        rdata_nxt = {7'h00, timeout_r};
      end
    end
  end

  // ****************************************************************
  // Read data register
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (clk_en) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Both pins are asynchronous to clk, so each passes two flops first
  always_comb begin
    pin_sync_nxt = {pin_sync_r[0], mp_pin_in};
    therm_sync_nxt = {therm_sync_r[0], thermal_trip};
    pin_last_nxt = pin_sync;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_r <= 2'b00;
      therm_sync_r <= 2'b00;
      pin_last_r <= 1'b0;
    end else if (clk_en) begin
      pin_sync_r <= pin_sync_nxt;
      therm_sync_r <= therm_sync_nxt;
      pin_last_r <= pin_last_nxt;
    end
  end

  // ****************************************************************
  // Reset routing and multipurpose pin
  // ****************************************************************
  logic [1:0] pin_fn;
  logic wdt_src, pin_level;
  assign pin_fn = pin_cfg_r[WDR_PIN_FN_LO +: 2];
  // Secondary input bit lets software assert the watchdog source too
  assign wdt_src = (timeout_r || rst_src_r[WDR_RST_WDT2]) &&
                   !rst_src_r[WDR_RST_WDT_DIS];
  // Thermal trip reaches the output two clocks late, after its flops
  assign power_good_output = !(wdt_src ||
    (rst_src_r[WDR_RST_THERM] && therm_sync));
  always_comb begin
    case (pin_fn)
      WDR_FN_WDT: pin_level = timeout_r;
      WDR_FN_LED: pin_level = 1'b1;
      default: pin_level = count_reg_r[0];
    endcase
  end
  // Open drain drives only the low level
  logic drv_level;
  assign drv_level = pin_level ^ pin_cfg_r[WDR_PIN_POL];
  assign mp_pin_out = drv_level;
  assign mp_pin_oe = !pin_cfg_r[WDR_PIN_DIR] &&
    (!pin_cfg_r[WDR_PIN_OD] || !drv_level);
  assign led_on = (pin_fn == WDR_FN_LED) && !pin_cfg_r[WDR_PIN_DIR];
  assign edge_event = (pin_fn == WDR_FN_EDGE) && pin_cfg_r[WDR_PIN_DIR] &&
    (pin_sync != pin_last_r);
  assign gpio_level = {7'h00, pin_sync ^ pin_cfg_r[WDR_PIN_POL]};
  assign io_rdata = rdata_r;
endmodule : wdr_watchdog
`default_nettype wire

// File: tb/wdr_watchdog_assertions.sv
// Checker for the watchdog port behaviour
`timescale 1ns/1ps
`default_nettype none
module wdr_watchdog_checker #(
  parameter longint SEC_CYCLES = 10,
  parameter int MIN_SECONDS = 3
) (
  // Watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_rdata,
  input wire logic thermal_trip,
  input wire logic power_good_output,
  input wire logic mp_pin_oe,
  input wire logic led_on,
  input wire logic edge_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_null_rd;
    io_rd && clk_en && io_addr == 16'h0000;
  endsequence
  // Low without thermal cause means a latched timeout or a set WDT2 source bit
  sequence s_pg_latched;
    !power_good_output && !thermal_trip && !$past(thermal_trip) &&
    !$past(thermal_trip, 2) && !io_wr;
  endsequence
  a_reset_pg_high: assert property (
    $rose(rst_n) |-> power_good_output) else $error("pg low after reset");
  a_reset_pin_idle: assert property (
    $rose(rst_n) |-> !mp_pin_oe && io_rdata == 8'h00)
    else $error("pin or rdata busy after reset");
  a_rdata_hold: assert property (
    !(io_rd && clk_en) |=> $stable(io_rdata)) else $error("rdata moved");
  a_freeze_state: assert property (
    !clk_en |=> $stable(io_rdata) && $stable(mp_pin_oe) && $stable(led_on))
    else $error("state moved while frozen");
  a_fn_exclusive: assert property (
    !(led_on && edge_event)) else $error("two pin functions at once");
  a_timeout_held: assert property (
    s_pg_latched |=> !power_good_output) else $error("timeout dropped");
  a_pg_rise_cause: assert property (
    $rose(power_good_output) |-> $past(io_wr) ||
    ($past(thermal_trip, 3) && !$past(thermal_trip, 2)))
    else $error("pg rose with no cause");
  a_unmapped_zero: assert property (
    s_null_rd |=> io_rdata == 8'h00) else $error("unmapped read not zero");
endmodule : wdr_watchdog_checker
bind wdr_watchdog wdr_watchdog_checker #(
  .SEC_CYCLES(SEC_CYCLES), .MIN_SECONDS(MIN_SECONDS)
) u_chk (
  .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .io_wr(io_wr), .io_rd(io_rd),
  .io_addr(io_addr), .io_rdata(io_rdata), .thermal_trip(thermal_trip),
  .power_good_output(power_good_output), .mp_pin_oe(mp_pin_oe),
  .led_on(led_on), .edge_event(edge_event)
);
`default_nettype wire

// File: tb/wdr_host_model.sv
// Host software model issuing I/O cycles
`timescale 1ns/1ps
`default_nettype none
module wdr_host_model (
  // Host bus
  input wire logic clk,
  input wire logic [7:0] io_rdata,
  output logic io_wr,
  output logic io_rd,
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata
);
  initial begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
    io_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    @(negedge clk);
    d = io_rdata;
  endtask : rd
  // Locks again at the end so a stray write cannot reach the config space
  task automatic open_base(output logic [15:0] b);
    logic [7:0] h;
    logic [7:0] l;
    wr(16'h004E, 8'h55);
    wr(16'h004E, 8'h07);
    wr(16'h004F, 8'h0A);
    wr(16'h004E, 8'h60);
    rd(16'h004F, h);
    wr(16'h004E, 8'h61);
    rd(16'h004F, l);
    wr(16'h004E, 8'hAA);
    b = {h, l};
  endtask : open_base
endmodule : wdr_host_model
`default_nettype wire

// File: tb/tb.sv
// Testbench for the watchdog with reset routing
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wdr_pkg::*;
  localparam int T = 10;
  logic clk, rst_n, clk_en, io_wr, io_rd, thermal_trip, mp_pin_in;
  logic power_good_output, mp_pin_out, mp_pin_oe, led_on, edge_event;
  logic [15:0] io_addr, base;
  logic [7:0] io_wdata, io_rdata, gpio_level, v;
  int bad_count = 0;
  int checks_done = 0;
  wdr_watchdog #(.SEC_CYCLES(T), .MIN_SECONDS(3)) u_dut (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .io_wr(io_wr),
    .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .thermal_trip(thermal_trip),
    .power_good_output(power_good_output), .mp_pin_in(mp_pin_in),
    .mp_pin_out(mp_pin_out), .mp_pin_oe(mp_pin_oe), .led_on(led_on),
    .edge_event(edge_event), .gpio_level(gpio_level));
  wdr_host_model u_host (.clk(clk), .io_rdata(io_rdata), .io_wr(io_wr),
    .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input string n, input logic [7:0] s, e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic reg_wr(input logic [7:0] o, d);
    u_host.wr(base + {8'h00, o}, d);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] o, e, input string n);
    u_host.rd(base + {8'h00, o}, v);
    check(n, v, e);
  endtask : reg_rd
  task automatic wait_pg(input logic l, input int m);
    int i = 0;
    while (power_good_output !== l && i < m) begin
      @(negedge clk);
      i++;
    end
    check("pg", {7'h00, power_good_output}, {7'h00, l});
    if (power_good_output !== l) stop_test();
  endtask : wait_pg
  task automatic t_regs();
    u_host.open_base(base);
    check("base", base[15:8], 8'h0A);
    check("base_lo", base[7:0], 8'h00);
    reg_rd(WDR_OFS_COUNT, 8'h00, "count");
    reg_rd(WDR_OFS_UNIT, 8'h00, "unit");
    reg_rd(WDR_OFS_PIN_CFG, 8'h01, "pin");
    reg_wr(WDR_OFS_UNIT, 8'hFF);
    reg_rd(WDR_OFS_UNIT, 8'h80, "unit_rsv");
    reg_wr(WDR_OFS_RST_SRC, 8'hFF);
    reg_rd(WDR_OFS_RST_SRC, 8'h07, "rst_rsv");
    reg_wr(WDR_OFS_PIN_CFG, 8'hFF);
    reg_rd(WDR_OFS_PIN_CFG, 8'h8F, "pin_rsv");
    u_host.rd(16'h0000, v);
    check("unmapped", v, 8'h00);
  endtask : t_regs
  task automatic t_therm();
    reg_wr(WDR_OFS_RST_SRC, 8'h02);
    thermal_trip = 1'b1;
    wait_pg(1'b0, 3);
    reg_wr(WDR_OFS_RST_SRC, 8'h00);
    wait_pg(1'b1, 3);
    repeat (4) @(negedge clk);
    check("therm_off", {7'h00, power_good_output}, 8'h01);
    thermal_trip = 1'b0;
  endtask : t_therm
  // A count write restarts the tick phase, so expiry is exact
  task automatic t_expire(input logic [7:0] u, input int n, tick);
    reg_wr(WDR_OFS_UNIT, u);
    reg_wr(WDR_OFS_COUNT, n[7:0]);
    repeat (n * tick - 2) @(negedge clk);
    check("early", {7'h00, power_good_output}, 8'h01);
    wait_pg(1'b0, 3);
    u_host.rd(base + {8'h00, WDR_OFS_CTRL}, v);
    check("status", v, 8'h01);
    reg_rd(WDR_OFS_COUNT, 8'h00, "stopped");
    reg_wr(WDR_OFS_CTRL, 8'h00);
    wait_pg(1'b1, 3);
  endtask : t_expire
  task automatic t_hold();
    reg_wr(WDR_OFS_RST_SRC, 8'h01);
    reg_wr(WDR_OFS_CTRL, 8'h01);
    repeat (3) @(negedge clk);
    check("wdt_off", {7'h00, power_good_output}, 8'h01);
    reg_wr(WDR_OFS_RST_SRC, 8'h00);
    wait_pg(1'b0, 3);
    reg_wr(WDR_OFS_CTRL, 8'h00);
    reg_wr(WDR_OFS_COUNT, 8'h03);
    clk_en = 1'b0;
    repeat (4 * T) @(negedge clk);
    clk_en = 1'b1;
    reg_rd(WDR_OFS_COUNT, 8'h03, "frozen");
    reg_wr(WDR_OFS_COUNT, 8'h00);
    repeat (12 * T) @(negedge clk);
    check("zero_off", {7'h00, power_good_output}, 8'h01);
  endtask : t_hold
  task automatic t_gpio();
    reg_wr(WDR_OFS_PIN_CFG, 8'h01);
    mp_pin_in = 1'b1;
    repeat (4) @(negedge clk);
    check("gpio", gpio_level, 8'h01);
    reg_wr(WDR_OFS_PIN_CFG, 8'h03);
    check("gpio_inv", gpio_level, 8'h00);
  endtask : t_gpio
  task automatic t_pin();
    reg_wr(WDR_OFS_RST_SRC, 8'h01);
    reg_wr(WDR_OFS_PIN_CFG, 8'h0C);
    check("wdt_oe", {7'h00, mp_pin_oe}, 8'h01);
    check("wdt_low", {7'h00, mp_pin_out}, 8'h00);
    reg_wr(WDR_OFS_CTRL, 8'h01);
    check("wdt_high", {7'h00, mp_pin_out}, 8'h01);
    reg_wr(WDR_OFS_PIN_CFG, 8'h8C);
    check("od_release", {7'h00, mp_pin_oe}, 8'h00);
    reg_wr(WDR_OFS_PIN_CFG, 8'h8E);
    check("od_sink", {6'h00, mp_pin_oe, mp_pin_out}, 8'h02);
    reg_wr(WDR_OFS_CTRL, 8'h00);
    reg_wr(WDR_OFS_PIN_CFG, 8'h04);
    check("led", {6'h00, led_on, mp_pin_out}, 8'h03);
    reg_wr(WDR_OFS_PIN_CFG, 8'h09);
    mp_pin_in = 1'b0;
    repeat (2) @(negedge clk);
    check("edge", {7'h00, edge_event}, 8'h01);
    @(negedge clk);
    check("edge_end", {7'h00, edge_event}, 8'h00);
  endtask : t_pin
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    thermal_trip = 1'b0;
    mp_pin_in = 1'b0;
    base = 16'h0000;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    t_therm();
    t_expire(8'h80, 255, T);
    t_expire(8'h00, 2, 3 * T);
    t_hold();
    t_gpio();
    t_pin();
    stop_test();
  end
endmodule : tb
`default_nettype wire
